// ==== hdl/twa_pkg.sv ====
// Constants and carrier types for the trapping word adder slice
package twa_pkg;
	// Instruction field positions
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int SRC1_HI = 25;
	localparam int SRC1_LO = 21;
	localparam int SRC2_HI = 20;
	localparam int SRC2_LO = 16;
	localparam int DST_HI = 15;
	localparam int DST_LO = 11;
	localparam int RSV_HI = 10;
	localparam int RSV_LO = 6;
	localparam int FUN_HI = 5;
	localparam int FUN_LO = 0;
	// Encodings
	localparam logic [5:0] OPC_REGOP = 6'h00;
	localparam logic [5:0] FUN_ADD_TRAP = 6'h20;
	localparam logic [5:0] FUN_ADD_NOTRAP = 6'h21;
	localparam logic [4:0] RSV_ZERO = 5'h00;
	// Values after reset
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [4:0] IDX_RST = 5'h00;
	// Cycles from request to result
	localparam int LATENCY_CYC = 2;

	// Register file write port
	typedef struct packed {
		logic en;
		logic [4:0] idx;
		logic [31:0] data;
	} twa_wb_t;

	// Register file read indices
	typedef struct packed {
		logic [4:0] first_source_index;
		logic [4:0] second_source_index;
	} twa_rd_t;

	// Complete state of the slice
	typedef struct packed {
		logic s1_valid;
		logic [31:0] s1_instr;
		twa_rd_t rd;
		twa_wb_t wb;
		logic ovf_exc;
		logic rsv_fault;
		logic done;
	} twa_state_t;
endpackage : twa_pkg

// ==== hdl/twa_trapping_word_adder.sv ====
// Execution slice for the trapping and non-trapping word additions
`timescale 1ns/1ps
`default_nettype none
module twa_trapping_word_adder (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Instruction issue from decode
	input wire logic instr_valid,
	input wire logic [31:0] instr_word,
	// Register file read port
	output twa_pkg::twa_rd_t rd_req,
	input wire logic [31:0] first_source_data,
	input wire logic [31:0] second_source_data,
	// Register file write port
	output twa_pkg::twa_wb_t wb,
	// Results and exceptions
	output logic result_done,
	output logic overflow_exception,
	output logic reserved_fault
);
	// Timing of one add, counted in rising edges:
	// the issue edge captures the word and the two source indices, so the
	// register file answers during the following cycle from the held
	// indices; the next edge registers the write, the trap and the
	// reserved-field flag, each as a one-cycle pulse.
	// A new word may be issued on every edge. Each stage works only on its
	// own copy of the word, so back-to-back adds never mix their fields.
	// Hazard: the read data must belong to the indices now in rd_req, so
	// the register file has to return them within the same cycle.
	// Limitation: no forwarding; a write from this slice lands one edge
	// after its pulse, and the issuing side must respect that.

	// Whole state of the slice, and its next value
	twa_pkg::twa_state_t st_ff;
	twa_pkg::twa_state_t nxt_st;
	logic [32:0] sum33;
	logic ovf;
	logic s1_trap_op;
	logic s1_notrap_op;

	// Recognise one of the two word additions
	function automatic logic is_add(input logic [31:0] w,
		input logic [5:0] fun);
		is_add = (w[twa_pkg::OPC_HI:twa_pkg::OPC_LO] == twa_pkg::OPC_REGOP)
			&& (w[twa_pkg::FUN_HI:twa_pkg::FUN_LO] == fun);
	endfunction

	// Sign-extended sum and overflow test
	// The 33rd bit copies bit 31 of each operand, so a signed overflow
	// shows up as disagreement between the two top bits of the sum.
	// The sum is formed for every word; only decoded adds use it.
	always_comb begin
		sum33 = {first_source_data[31], first_source_data}
			+ {second_source_data[31], second_source_data};
		ovf = sum33[32] != sum33[31];
		s1_trap_op = st_ff.s1_valid
			&& is_add(st_ff.s1_instr, twa_pkg::FUN_ADD_TRAP);
		s1_notrap_op = st_ff.s1_valid
			&& is_add(st_ff.s1_instr, twa_pkg::FUN_ADD_NOTRAP);
	end

	// Next state: capture in stage one, resolve in stage two
	// Indices follow every issued word, add or not, so the register file
	// always sees the fields of the last issued word.
	// Result pulses fall back to zero by themselves on the following edge.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1_valid = instr_valid
			&& (is_add(instr_word, twa_pkg::FUN_ADD_TRAP)
			|| is_add(instr_word, twa_pkg::FUN_ADD_NOTRAP));
		if (instr_valid) begin
			nxt_st.s1_instr = instr_word;
			nxt_st.rd.first_source_index =
				instr_word[twa_pkg::SRC1_HI:twa_pkg::SRC1_LO];
			nxt_st.rd.second_source_index =
				instr_word[twa_pkg::SRC2_HI:twa_pkg::SRC2_LO];
		end
		nxt_st.done = s1_trap_op || s1_notrap_op;
		// Write only when no trap is taken
		nxt_st.wb.en = (s1_trap_op && !ovf) || s1_notrap_op;
		nxt_st.wb.idx = st_ff.s1_instr[twa_pkg::DST_HI:twa_pkg::DST_LO];
		nxt_st.wb.data = sum33[31:0];
		nxt_st.ovf_exc = s1_trap_op && ovf;
		// Non-zero reserved bits are flagged but not otherwise defined
		nxt_st.rsv_fault = nxt_st.done
			&& (st_ff.s1_instr[twa_pkg::RSV_HI:twa_pkg::RSV_LO]
			!= twa_pkg::RSV_ZERO);
	end

	// State register
	// Reset clears every pulse, so no false write follows release.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_ff <= '{s1_valid: 1'b0, s1_instr: twa_pkg::WORD_RST,
				rd: '{twa_pkg::IDX_RST, twa_pkg::IDX_RST},
				wb: '{1'b0, twa_pkg::IDX_RST, twa_pkg::WORD_RST},
				ovf_exc: 1'b0, rsv_fault: 1'b0, done: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign rd_req = st_ff.rd;
	assign wb = st_ff.wb;
	assign result_done = st_ff.done;
	assign overflow_exception = st_ff.ovf_exc;
	assign reserved_fault = st_ff.rsv_fault;

	// Checks on the read indices and the resolved result
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// A trap and a write never come together
	a_trap_no_write: assert property (overflow_exception |-> !wb.en)
		else $error("write enabled together with overflow trap");

	// An overflowing trapping add traps and suppresses its write
	a_trap_cause: assert property (
		s1_trap_op && ovf |=> overflow_exception && !wb.en)
		else $error("overflow trap missing or write not suppressed");

	// A trap pulse belongs to a resolved add
	a_trap_only_done: assert property (
		overflow_exception |-> result_done)
		else $error("overflow trap without a result");

	// Written data is the 32-bit sum of the two read words
	a_write_sum: assert property (
		wb.en |-> wb.data
		== $past(first_source_data) + $past(second_source_data))
		else $error("written data is not the sum");

	// A clean trapping add writes and does not trap
	a_write_clean: assert property (
		s1_trap_op && !ovf |=> wb.en && !overflow_exception)
		else $error("clean add did not write");

	// A resolved trapping add without a trap must write
	a_clean_writes: assert property (
		$past(s1_trap_op) && !overflow_exception |-> wb.en)
		else $error("trapping add neither trapped nor wrote");

	// Writes go to the destination field of the resolved word
	a_write_idx: assert property (
		wb.en |-> wb.idx == $past(st_ff.s1_instr[15:11]))
		else $error("write to the wrong destination");

	// A write belongs to a resolved add
	a_write_only_done: assert property (
		wb.en |-> result_done)
		else $error("write without a result");

	// A trap only with like signs and a flipped sign in the sum
	a_ovf_formula: assert property (
		overflow_exception |->
		($past(first_source_data[31]) == $past(second_source_data[31]))
		&& (wb.data[31] != $past(first_source_data[31])))
		else $error("overflow flagged without sign overflow");

	// Trap decision matches the sign rule exactly, in both directions
	a_ovf_exact: assert property (
		$past(s1_trap_op) |-> overflow_exception
		== (($past(first_source_data[31])
		== $past(second_source_data[31]))
		&& (wb.data[31] != $past(first_source_data[31]))))
		else $error("overflow decision disagrees with sign rule");

	// The non-trapping add always writes and never traps
	a_notrap_never: assert property (
		s1_notrap_op |=> wb.en && !overflow_exception)
		else $error("non-trapping add trapped or did not write");

	// A decoded trapping add resolves two sampling edges after issue
	a_decode_latency: assert property (
		instr_valid && is_add(instr_word, twa_pkg::FUN_ADD_TRAP)
		|-> ##2 result_done && (wb.idx == $past(instr_word[15:11], 2)))
		else $error("decoded add not resolved in two cycles");

	// Words that are not adds produce no result
	a_ignore_other: assert property (
		instr_valid && !is_add(instr_word, twa_pkg::FUN_ADD_TRAP)
		&& !is_add(instr_word, twa_pkg::FUN_ADD_NOTRAP)
		|-> ##2 !result_done)
		else $error("result pulse for a word that is not an add");

	// Every result pulse traces back to a decoded add
	a_done_cause: assert property (
		result_done |-> $past(s1_trap_op || s1_notrap_op))
		else $error("result pulse without a decoded add");

	// Source indices come from the issued word
	a_src_index: assert property (
		instr_valid |=> rd_req.first_source_index
		== $past(instr_word[25:21]) && rd_req.second_source_index
		== $past(instr_word[20:16]))
		else $error("source indices not taken from instruction");

	// Source indices hold while nothing is issued
	a_src_hold: assert property (
		!instr_valid |=> $stable(rd_req))
		else $error("source indices moved without an issue");

	// Reserved flag only with a result
	a_rsv_flag: assert property (reserved_fault |-> result_done)
		else $error("reserved fault without a result");

	// Non-zero reserved field on a resolved add raises the flag
	a_rsv_cause: assert property (
		result_done && ($past(st_ff.s1_instr[10:6]) != 5'h00)
		|-> reserved_fault)
		else $error("reserved field set but not flagged");

	// Clear reserved field keeps the flag low
	a_rsv_clean: assert property (
		result_done && ($past(st_ff.s1_instr[10:6]) == 5'h00)
		|-> !reserved_fault)
		else $error("reserved flag raised for a clear field");

	// Main scenarios worth seeing at least once
	c_clean_add: cover property (result_done && wb.en && !reserved_fault);
	c_trap_add: cover property (overflow_exception);
	c_notrap_ovf: cover property (s1_notrap_op && ovf);
	c_reserved_add: cover property (reserved_fault && wb.en);
	c_back_to_back: cover property (result_done [*3]);
endmodule // twa_trapping_word_adder
`default_nettype wire

// ==== test/twa_regfile_model.sv ====
// Behavioural general register file on the far side of the slice
`timescale 1ns/1ps
`default_nettype none
module twa_regfile_model (
	// Clock
	input wire logic clk,
	// Read port
	input wire twa_pkg::twa_rd_t rd_req,
	output logic [31:0] first_source_data,
	output logic [31:0] second_source_data,
	// Write port
	input wire twa_pkg::twa_wb_t wb
);
	logic [31:0] mem [32];
	// Reads follow the held indices
	assign first_source_data = mem[rd_req.first_source_index];
	assign second_source_data = mem[rd_req.second_source_index];
	// Commit writes from the slice
	always @(posedge clk) begin
		if (wb.en) begin
			mem[wb.idx] <= wb.data;
		end
	end
endmodule // twa_regfile_model
`default_nettype wire

// ==== test/test_trapping_word_adder.sv ====
// Self-checking bench for the trapping word adder slice
`timescale 1ns/1ps
`default_nettype none
module test_trapping_word_adder;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic instr_valid = 1'b0;
	logic [31:0] instr_word = 32'h0000_0000;
	twa_pkg::twa_rd_t rd_req;
	twa_pkg::twa_wb_t wb;
	logic [31:0] src1, src2;
	logic result_done, overflow_exception, reserved_fault;
	int fail_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Clock and hang guard
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	twa_trapping_word_adder twa_trapping_word_adder_inst (.clk(clk),
		.reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
		.rd_req(rd_req), .first_source_data(src1),
		.second_source_data(src2), .wb(wb), .result_done(result_done),
		.overflow_exception(overflow_exception),
		.reserved_fault(reserved_fault));
	twa_regfile_model twa_regfile_model_inst (.clk(clk), .rd_req(rd_req),
		.first_source_data(src1), .second_source_data(src2), .wb(wb));
	task automatic tally_and_finish();
		$display("Compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Single compare point for every check
	task automatic check(input string what, input logic [50:0] seen,
		input logic [50:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Issue one word, judge result two edges later; idx/data moot if no write
	task automatic run_op(input string name, input logic [31:0] word,
		input logic [31:0] a, input logic [31:0] b, input logic [40:0] exp);
		@(negedge clk);
		twa_regfile_model_inst.mem[1] = a;
		twa_regfile_model_inst.mem[2] = b;
		instr_valid = 1'b1;
		instr_word = word;
		@(negedge clk);
		instr_valid = 1'b0;
		@(negedge clk);
		// Pulses stand between the second and third edge after issue
		check(name, {rd_req, wb.en, wb.en ? {wb.idx, wb.data} : exp[39:3],
			result_done, overflow_exception, reserved_fault},
			{10'h022, exp});
		$display("Test %s done", name);
	endtask
	task automatic t_sums();
		run_op("plain", 32'h0022_1820, 32'h0000_0005, 32'h0000_0007,
			{1'b1, 5'h03, 32'h0000_000C, 3'b100});
		run_op("edge_ok", 32'h0022_1820, 32'h7FFF_FFFF, 32'hFFFF_FFFF,
			{1'b1, 5'h03, 32'h7FFF_FFFE, 3'b100});
	endtask
	task automatic t_overflow();
		run_op("ovf_pos", 32'h0022_1820, 32'h7FFF_FFFF, 32'h0000_0001,
			{1'b0, 5'h00, 32'h0000_0000, 3'b110});
		run_op("ovf_neg", 32'h0022_1820, 32'h8000_0000, 32'hFFFF_FFFF,
			{1'b0, 5'h00, 32'h0000_0000, 3'b110});
	endtask
	task automatic t_nontrap();
		run_op("no_trap", 32'h0022_1821, 32'h7FFF_FFFF, 32'h0000_0001,
			{1'b1, 5'h03, 32'h8000_0000, 3'b100});
	endtask
	task automatic t_reserved();
		run_op("reserved", 32'h0022_1FE0, 32'h0000_0002, 32'h0000_0003,
			{1'b1, 5'h03, 32'h0000_0005, 3'b101});
	endtask
	task automatic t_ignored();
		run_op("opcode", 32'h2022_1820, 32'h0000_0001, 32'h0000_0001,
			{1'b0, 5'h00, 32'h0000_0000, 3'b000});
		run_op("funct", 32'h0022_1822, 32'h0000_0001, 32'h0000_0001,
			{1'b0, 5'h00, 32'h0000_0000, 3'b000});
	endtask
	// Reset, then scenarios
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		t_sums();
		t_overflow();
		t_nontrap();
		t_reserved();
		t_ignored();
		tally_and_finish();
	end
endmodule // test_trapping_word_adder
`default_nettype wire
